// *** rtl/tcs_pkg.sv ***
// Package: constants and carriers for the transformer circuit supervision.
// Assumes one 40 MHz clock and a measurement front end on that clock.
// Behaviour
// - Current alarm when a phase is below low and another above high, held for delay.
// - High current threshold 0.00-10.00 xIn, step 0.01, default 2.0.
// - Low current threshold 0.00-10.00 xIn, step 0.01, default 0.2.
// - Current delay definite time 0.04-600 s, step 0.02 s, default 0.10 s.
// - High condition clears only below 0.97 of high threshold.
// - Low condition clears only above 1.03 of low threshold.
// - Current alarm rising gives on event when enabled; enable defaults on.
// - Current alarm falling gives off event when enabled; enable defaults on.
// - Largest and smallest phase current always presented.
// - On current alarm store time stamp, largest and smallest current.
// - Derive negative sequence voltage and current from line voltages and currents.
// - Voltage alarm when sequence voltage above, sequence current below, held.
// - Sequence voltage threshold 0.0-200.0 %, step 0.1 %, default 34.6 %.
// - Sequence current threshold 0.0-200.0 %, step 0.1 %, default 100.0 %.
// - Voltage delay definite time 0.04-600 s, step 0.02 s, default 0.10 s.
// - Voltage conditions clear only after 3 % hysteresis of pickup value.
// - Voltage alarm on and off events, each with own enable, default on.
// - On voltage alarm store time stamp, sequence voltage and current.
// - Voltage alarm offered to block voltage based protection.
package tcs_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_EVT_EN    = 8'h00;
  localparam logic [7:0] OFS_CT_HIGH   = 8'h04;
  localparam logic [7:0] OFS_CT_LOW    = 8'h08;
  localparam logic [7:0] OFS_CT_DELAY  = 8'h0C;
  localparam logic [7:0] OFS_NSV_THR   = 8'h10;
  localparam logic [7:0] OFS_NSC_THR   = 8'h14;
  localparam logic [7:0] OFS_VT_DELAY  = 8'h18;
  localparam logic [7:0] OFS_STATUS    = 8'h1C;
  localparam logic [7:0] OFS_CT_LIVE   = 8'h20;
  localparam logic [7:0] OFS_VT_LIVE   = 8'h24;
  localparam logic [7:0] OFS_CT_REC_TS = 8'h28;
  localparam logic [7:0] OFS_CT_REC_V  = 8'h2C;
  localparam logic [7:0] OFS_VT_REC_TS = 8'h30;
  localparam logic [7:0] OFS_VT_REC_V  = 8'h34;

  // Event enable bit positions
  localparam int EN_CURRENT_SUP_ALARM_ON_EVENT_ENABLE  = 0;
  localparam int EN_CURRENT_SUP_ALARM_OFF_EVENT_ENABLE = 1;
  localparam int EN_VOLTAGE_SUP_ALARM_ON_EVENT_ENABLE  = 2;
  localparam int EN_VOLTAGE_SUP_ALARM_OFF_EVENT_ENABLE = 3;

  // Reset values and ranges (current 0.01 xIn, sequence 0.1 %)
  localparam logic [3:0]  RST_EVT_EN  = 4'hF;
  localparam logic [15:0] RST_CT_HIGH = 16'h00C8; // 2.00 xIn
  localparam logic [15:0] RST_CT_LOW  = 16'h0014; // 0.20 xIn
  localparam logic [15:0] RST_NSV_THR = 16'h015A; // 34.6 %
  localparam logic [15:0] RST_NSC_THR = 16'h03E8; // 100.0 %
  localparam logic [15:0] RST_DELAY   = 16'h0005; // 0.10 s
  localparam logic [15:0] MAX_CT_THR  = 16'h03E8;
  localparam logic [15:0] MAX_SEQ_THR = 16'h07D0;
  localparam logic [15:0] MIN_DELAY   = 16'h0002; // 0.04 s
  localparam logic [15:0] MAX_DELAY   = 16'h7530; // 600.00 s

  // Hysteresis ratios in percent
  localparam int unsigned HYST_DOWN = 97;
  localparam int unsigned HYST_UP   = 103;

  // Timing: delay step and clock rate
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned DELAY_STEP_MS = 20;
  localparam int unsigned STEP_CYCLES   = CLK_HZ / 1000 * DELAY_STEP_MS;

  // Rotation constant sqrt(3)/2 in 1/1024, and 1/3 in 1/1024
  localparam logic signed [19:0] ROT_K   = 20'sd887;
  localparam logic [19:0]        THIRD_K = 20'd341;

  // Channel timer states
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_TIMING = 2'b01,
    ST_ALARM  = 2'b10
  } sup_state_e;

  // Three phasors, rectangular, signed, 0.1 % of nominal
  typedef struct packed {
    logic signed [15:0] a_re;
    logic signed [15:0] a_im;
    logic signed [15:0] b_re;
    logic signed [15:0] b_im;
    logic signed [15:0] c_re;
    logic signed [15:0] c_im;
  } phasor3_s;

  // One measurement set from the front end
  typedef struct packed {
    logic [15:0] ia_mag;
    logic [15:0] ib_mag;
    logic [15:0] ic_mag;
    phasor3_s    volt;
    phasor3_s    curr;
  } meas_s;

endpackage

// *** rtl/transformer_circuit_supervision.sv ***
// Current and voltage transformer circuit supervision with APB registers.
// Assumes measurements and time stamp arrive on pclk from same-domain logic.
module transformer_circuit_supervision #(
  parameter int unsigned STEP_CYCLES = tcs_pkg::STEP_CYCLES
) (
  // Clock and reset
  input  wire logic           pclk,
  input  wire logic           presetn,
  // APB slave
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [7:0]     paddr,
  input  wire logic [31:0]    pwdata,
  output logic      [31:0]    prdata,
  output logic                pready,
  output logic                pslverr,
  // Measurements and real time stamp
  input  wire tcs_pkg::meas_s meas,
  input  wire logic [31:0]    timestamp,
  // Alarms and events
  output logic                ct_alarm,
  output logic                vt_alarm,
  output logic                current_sup_alarm_on_event_enable_event,
  output logic                current_sup_alarm_off_event_enable_event,
  output logic                voltage_sup_alarm_on_event_enable_event,
  output logic                voltage_sup_alarm_off_event_enable_event
);
  import tcs_pkg::*;

  // Saturate a written setting into its range
  function automatic logic [15:0] sat(input logic [31:0] v,
                                      input logic [15:0] lo,
                                      input logic [15:0] hi);
    if (v[15:0] < lo || v[31:16] != 16'h0000)
      sat = (v[31:16] != 16'h0000) ? hi : lo;
    else if (v[15:0] > hi)
      sat = hi;
    else
      sat = v[15:0];
  endfunction

  // Value times a percentage factor, wide enough for no overflow
  function automatic logic [31:0] mulp(input logic [15:0] v,
                                       input int unsigned p);
    mulp = 32'(v) * p;
  endfunction

  // Negative sequence magnitude: |A + a2*B + a*C| / 3
  function automatic logic [15:0] neg_seq(input phasor3_s p);
    logic signed [19:0] re;
    logic signed [19:0] im;
    logic signed [39:0] kr;
    logic signed [39:0] ki;
    logic [19:0]        ar;
    logic [19:0]        ai;
    logic [19:0]        mag;
    logic [39:0]        div;
    kr = (20'(p.b_im) - 20'(p.c_im)) * ROT_K;
    ki = (20'(p.c_re) - 20'(p.b_re)) * ROT_K;
    re = 20'(p.a_re) - ((20'(p.b_re) + 20'(p.c_re)) >>> 1)
         + 20'(kr >>> 10);
    im = 20'(p.a_im) - ((20'(p.b_im) + 20'(p.c_im)) >>> 1)
         + 20'(ki >>> 10);
    ar = re[19] ? 20'(-re) : 20'(re);
    ai = im[19] ? 20'(-im) : 20'(im);
    // Max plus half min: cheap magnitude, never low, up to about 12 percent high
    mag = (ar > ai) ? ar + (ai >> 1) : ai + (ar >> 1);
    div = 40'(mag) * 40'(THIRD_K);
    neg_seq = (div[39:26] != 14'h0000) ? 16'hFFFF : div[25:10];
  endfunction

  // Settings
  logic [3:0]  evt_en_r;
  logic [15:0] ct_high_r;
  logic [15:0] ct_low_r;
  logic [15:0] nsv_thr_r;
  logic [15:0] nsc_thr_r;
  logic [15:0] delay_r [2];

  // Measured values
  logic [15:0] largest_phase_current_r;
  logic [15:0] smallest_phase_current_r;
  logic [15:0] neg_seq_voltage_r;
  logic [15:0] neg_seq_current_r;

  // Pickup latches with hysteresis
  logic        hi_pick_r;
  logic        lo_pick_r;
  logic        nsv_pick_r;
  logic        nsc_pick_r;
  logic [1:0]  cond;

  // Channel timers, index 0 current, 1 voltage
  sup_state_e  st_r [2];
  logic [19:0] pre_r [2];
  logic [15:0] tick_r [2];
  logic [1:0]  alarm;
  logic [1:0]  alarm_d_r;

  // Records
  logic [31:0] ct_rec_ts_r;
  logic [31:0] ct_rec_v_r;
  logic [31:0] vt_rec_ts_r;
  logic [31:0] vt_rec_v_r;

  // APB decode
  logic        wr_en;
  logic        rd_setup;
  logic [31:0] rd_nxt;
  logic        err_nxt;
  logic        err_r;

  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;

  // Largest and smallest phase current, live
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      largest_phase_current_r  <= 16'h0000;
      smallest_phase_current_r <= 16'h0000;
    end
    else
    begin
      largest_phase_current_r <=
        (meas.ia_mag >= meas.ib_mag && meas.ia_mag >= meas.ic_mag) ?
        meas.ia_mag : (meas.ib_mag >= meas.ic_mag) ? meas.ib_mag :
        meas.ic_mag;
      smallest_phase_current_r <=
        (meas.ia_mag <= meas.ib_mag && meas.ia_mag <= meas.ic_mag) ?
        meas.ia_mag : (meas.ib_mag <= meas.ic_mag) ? meas.ib_mag :
        meas.ic_mag;
    end
  end

  // Negative sequence values, one cycle of latency
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      neg_seq_voltage_r <= 16'h0000;
      neg_seq_current_r <= 16'h0000;
    end
    else
    begin
      neg_seq_voltage_r <= neg_seq(meas.volt);
      neg_seq_current_r <= neg_seq(meas.curr);
    end
  end

  // Current pickups; compare scaled so no division is needed
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hi_pick_r <= 1'b0;
      lo_pick_r <= 1'b0;
    end
    else
    begin
      if (hi_pick_r)
        hi_pick_r <= !(mulp(largest_phase_current_r, 100) <
                       mulp(ct_high_r, HYST_DOWN));
      else
        hi_pick_r <= largest_phase_current_r > ct_high_r;
      if (lo_pick_r)
        lo_pick_r <= !(mulp(smallest_phase_current_r, 100) >
                       mulp(ct_low_r, HYST_UP));
      else
        lo_pick_r <= smallest_phase_current_r < ct_low_r;
    end
  end

  // Voltage pickups with 3 % reset band
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nsv_pick_r <= 1'b0;
      nsc_pick_r <= 1'b0;
    end
    else
    begin
      if (nsv_pick_r)
        nsv_pick_r <= !(mulp(neg_seq_voltage_r, 100) <
                        mulp(nsv_thr_r, HYST_DOWN));
      else
        nsv_pick_r <= neg_seq_voltage_r > nsv_thr_r;
      if (nsc_pick_r)
        nsc_pick_r <= !(mulp(neg_seq_current_r, 100) >
                        mulp(nsc_thr_r, HYST_UP));
      else
        nsc_pick_r <= neg_seq_current_r < nsc_thr_r;
    end
  end

  // Low below and high above are two different phases only if low is set at or below high; otherwise one phase can hold both
  assign cond[0] = hi_pick_r & lo_pick_r;
  assign cond[1] = nsv_pick_r & nsc_pick_r;

  // Definite time timers; prescaler restarts with each pickup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 2; i++)
      begin
        st_r[i]   <= ST_IDLE;
        pre_r[i]  <= 20'h0_0000;
        tick_r[i] <= 16'h0000;
      end
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        case (st_r[i])
          ST_IDLE:
          begin
            pre_r[i]  <= 20'h0_0000;
            tick_r[i] <= 16'h0000;
            if (cond[i])
              st_r[i] <= ST_TIMING;
          end
          ST_TIMING:
          begin
            if (!cond[i])
              st_r[i] <= ST_IDLE;
            else if (pre_r[i] == 20'(STEP_CYCLES - 1))
            begin
              pre_r[i]  <= 20'h0_0000;
              tick_r[i] <= tick_r[i] + 16'h0001;
              if (tick_r[i] + 16'h0001 >= delay_r[i])
                st_r[i] <= ST_ALARM;
            end
            else
              pre_r[i] <= pre_r[i] + 20'h0_0001;
          end
          ST_ALARM:
          begin
            // Drop in one cycle, well inside the reset time
            if (!cond[i])
              st_r[i] <= ST_IDLE;
          end
          default:
            st_r[i] <= ST_IDLE;
        endcase
      end
    end
  end

  assign alarm[0] = (st_r[0] == ST_ALARM);
  assign alarm[1] = (st_r[1] == ST_ALARM);
  assign ct_alarm = alarm[0];
  assign vt_alarm = alarm[1];

  // Edge events, one cycle pulses from flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      alarm_d_r    <= 2'b00;
      current_sup_alarm_on_event_enable_event  <= 1'b0;
      current_sup_alarm_off_event_enable_event <= 1'b0;
      voltage_sup_alarm_on_event_enable_event  <= 1'b0;
      voltage_sup_alarm_off_event_enable_event <= 1'b0;
    end
    else
    begin
      alarm_d_r    <= alarm;
      current_sup_alarm_on_event_enable_event  <= alarm[0] & ~alarm_d_r[0] & evt_en_r[EN_CURRENT_SUP_ALARM_ON_EVENT_ENABLE];
      current_sup_alarm_off_event_enable_event <= ~alarm[0] & alarm_d_r[0] & evt_en_r[EN_CURRENT_SUP_ALARM_OFF_EVENT_ENABLE];
      voltage_sup_alarm_on_event_enable_event  <= alarm[1] & ~alarm_d_r[1] & evt_en_r[EN_VOLTAGE_SUP_ALARM_ON_EVENT_ENABLE];
      voltage_sup_alarm_off_event_enable_event <= ~alarm[1] & alarm_d_r[1] & evt_en_r[EN_VOLTAGE_SUP_ALARM_OFF_EVENT_ENABLE];
    end
  end

  // Records taken on the cycle each alarm rises
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ct_rec_ts_r <= 32'h0000_0000;
      ct_rec_v_r  <= 32'h0000_0000;
      vt_rec_ts_r <= 32'h0000_0000;
      vt_rec_v_r  <= 32'h0000_0000;
    end
    else
    begin
      if (alarm[0] && !alarm_d_r[0])
      begin
        ct_rec_ts_r <= timestamp;
        ct_rec_v_r  <= {largest_phase_current_r,
                        smallest_phase_current_r};
      end
      if (alarm[1] && !alarm_d_r[1])
      begin
        vt_rec_ts_r <= timestamp;
        vt_rec_v_r  <= {neg_seq_voltage_r, neg_seq_current_r};
      end
    end
  end

  // Settings writes; out of range values saturate to the limits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      evt_en_r   <= RST_EVT_EN;
      ct_high_r  <= RST_CT_HIGH;
      ct_low_r   <= RST_CT_LOW;
      nsv_thr_r  <= RST_NSV_THR;
      nsc_thr_r  <= RST_NSC_THR;
      delay_r[0] <= RST_DELAY;
      delay_r[1] <= RST_DELAY;
    end
    else if (wr_en)
    begin
      case (paddr)
        OFS_EVT_EN:   evt_en_r   <= pwdata[3:0];
        OFS_CT_HIGH:  ct_high_r  <= sat(pwdata, 16'h0000, MAX_CT_THR);
        OFS_CT_LOW:   ct_low_r   <= sat(pwdata, 16'h0000, MAX_CT_THR);
        OFS_CT_DELAY: delay_r[0] <= sat(pwdata, MIN_DELAY, MAX_DELAY);
        OFS_NSV_THR:  nsv_thr_r  <= sat(pwdata, 16'h0000, MAX_SEQ_THR);
        OFS_NSC_THR:  nsc_thr_r  <= sat(pwdata, 16'h0000, MAX_SEQ_THR);
        OFS_VT_DELAY: delay_r[1] <= sat(pwdata, MIN_DELAY, MAX_DELAY);
        default:      ;
      endcase
    end
  end

  // Read mux; an unknown or misaligned address answers with an error
  always_comb
  begin
    rd_nxt  = 32'h0000_0000;
    err_nxt = 1'b0;
    case (paddr)
      OFS_EVT_EN:    rd_nxt = {28'h000_0000, evt_en_r};
      OFS_CT_HIGH:   rd_nxt = {16'h0000, ct_high_r};
      OFS_CT_LOW:    rd_nxt = {16'h0000, ct_low_r};
      OFS_CT_DELAY:  rd_nxt = {16'h0000, delay_r[0]};
      OFS_NSV_THR:   rd_nxt = {16'h0000, nsv_thr_r};
      OFS_NSC_THR:   rd_nxt = {16'h0000, nsc_thr_r};
      OFS_VT_DELAY:  rd_nxt = {16'h0000, delay_r[1]};
      OFS_STATUS:    rd_nxt = {24'h00_0000, nsv_pick_r, nsc_pick_r,
                               hi_pick_r, lo_pick_r,
                               st_r[1] == ST_TIMING,
                               st_r[0] == ST_TIMING, alarm[1], alarm[0]};
      OFS_CT_LIVE:   rd_nxt = {largest_phase_current_r,
                               smallest_phase_current_r};
      OFS_VT_LIVE:   rd_nxt = {neg_seq_voltage_r, neg_seq_current_r};
      OFS_CT_REC_TS: rd_nxt = ct_rec_ts_r;
      OFS_CT_REC_V:  rd_nxt = ct_rec_v_r;
      OFS_VT_REC_TS: rd_nxt = vt_rec_ts_r;
      OFS_VT_REC_V:  rd_nxt = vt_rec_v_r;
      default:       err_nxt = 1'b1;
    endcase
  end

  // Read data caught in the setup cycle so it leaves a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      err_r  <= 1'b0;
    end
    else if (rd_setup)
    begin
      prdata <= rd_nxt;
      err_r  <= err_nxt;
    end
  end

  // Zero wait states; the error shows only in the access phase
  assign pready  = 1'b1;
  assign pslverr = psel & penable & err_r;

endmodule // transformer_circuit_supervision

// *** verif/meas_frontend.sv ***
// Front-end model: magnitudes, phasors and a running time stamp.
// Assumes the bench drives its controls just after pclk edges.
module meas_frontend (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Bench controls
  input  wire logic [15:0] ia,
  input  wire logic [15:0] ib,
  input  wire logic [15:0] ic,
  input  wire logic        vt_fuse,
  // Toward the block
  output tcs_pkg::meas_s   meas,
  output logic [31:0]      timestamp
);
  timeunit 1ns;
  timeprecision 100ps;
  import tcs_pkg::*;

  // Healthy set is balanced; a blown fuse leaves one raised phase
  always_comb
  begin
    meas = '0;
    meas.ia_mag = ia;
    meas.ib_mag = ib;
    meas.ic_mag = ic;
    meas.curr.a_re = 16'(ia * 16'h000A); // Phase a only, so unbalanced
    meas.volt.a_re = vt_fuse ? 16'h05DC : 16'h03E8;
    meas.volt.b_re = vt_fuse ? 16'h0000 : 16'hFE0C;
    meas.volt.b_im = vt_fuse ? 16'h0000 : 16'hFC9E;
    meas.volt.c_re = meas.volt.b_re;
    meas.volt.c_im = vt_fuse ? 16'h0000 : 16'h0362;
  end

  // Stamp moves every cycle so a stale record cannot pass
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timestamp <= '0;
    else
      timestamp <= timestamp + 32'h0000_0001;
  end
endmodule // meas_frontend

// *** verif/tcs_asserts.sv ***
// Checker: port-level timing of alarms, events and bus errors.
// Assumes binding into the top module with its STEP_CYCLES.
module tcs_asserts #(
  parameter int unsigned STEP_CYCLES = 10
) (
  // Clock and reset
  input wire logic           pclk,
  input wire logic           presetn,
  // Bus answer
  input wire logic           pslverr,
  input wire logic [31:0]    prdata,
  // Measurements and outputs
  input wire tcs_pkg::meas_s meas,
  input wire logic           ct_alarm,
  input wire logic           vt_alarm,
  input wire logic           current_sup_alarm_on_event_enable_event,
  input wire logic           current_sup_alarm_off_event_enable_event,
  input wire logic           voltage_sup_alarm_on_event_enable_event,
  input wire logic           voltage_sup_alarm_off_event_enable_event
);
  timeunit 1ns;
  timeprecision 100ps;
  import tcs_pkg::*;
  localparam int LIM = int'(MIN_DELAY) * int'(STEP_CYCLES);
  int ct_lo;
  int vt_lo;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Low-time counters; saturate so long idles cannot wrap
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ct_lo <= 0;
      vt_lo <= 0;
    end
    else
    begin
      ct_lo <= ct_alarm ? 0 : (ct_lo < LIM ? ct_lo + 1 : ct_lo);
      vt_lo <= vt_alarm ? 0 : (vt_lo < LIM ? vt_lo + 1 : vt_lo);
    end
  end

  a_current_sup_alarm_on_event_enable_evt: assert property (
    current_sup_alarm_on_event_enable_event |-> $past(ct_alarm) && !$past(ct_alarm, 2))
    else $error("current on event without alarm rise");
  a_current_sup_alarm_off_event_enable_evt: assert property (
    current_sup_alarm_off_event_enable_event |-> !$past(ct_alarm) && $past(ct_alarm, 2))
    else $error("current off event without alarm fall");
  a_voltage_sup_alarm_on_event_enable_evt: assert property (
    voltage_sup_alarm_on_event_enable_event |-> $past(vt_alarm) && !$past(vt_alarm, 2))
    else $error("voltage on event without alarm rise");
  a_voltage_sup_alarm_off_event_enable_evt: assert property (
    voltage_sup_alarm_off_event_enable_event |-> !$past(vt_alarm) && $past(vt_alarm, 2))
    else $error("voltage off event without alarm fall");
  a_ct_min_delay: assert property (
    $rose(ct_alarm) |-> ct_lo >= LIM)
    else $error("current alarm before shortest delay");
  a_vt_min_delay: assert property (
    $rose(vt_alarm) |-> vt_lo >= LIM)
    else $error("voltage alarm before shortest delay");
  a_ct_zero_drop: assert property (
    (meas.ia_mag == '0 && meas.ib_mag == '0 && meas.ic_mag == '0) [*4]
    |=> !ct_alarm) else $error("current alarm with no current");
  a_err_data: assert property (
    pslverr |-> prdata == '0) else $error("error answer carries data");
endmodule // tcs_asserts

bind transformer_circuit_supervision tcs_asserts #(
  .STEP_CYCLES(STEP_CYCLES)
) u_chk (
  .pclk(pclk), .presetn(presetn), .pslverr(pslverr), .prdata(prdata),
  .meas(meas), .ct_alarm(ct_alarm), .vt_alarm(vt_alarm),
  .current_sup_alarm_on_event_enable_event(current_sup_alarm_on_event_enable_event), .current_sup_alarm_off_event_enable_event(current_sup_alarm_off_event_enable_event),
  .voltage_sup_alarm_on_event_enable_event(voltage_sup_alarm_on_event_enable_event), .voltage_sup_alarm_off_event_enable_event(voltage_sup_alarm_off_event_enable_event)
);

// *** verif/tb.sv ***
// Testbench: APB register checks and alarm scenarios on both channels.
// Assumes the front-end model and the bound checker are compiled.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import tcs_pkg::*;
  localparam int unsigned STEP = 10;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, timestamp, q, ts_ct, ts_vt;
  logic [15:0] ia = '0, ib = '0, ic = '0;
  logic        vt_fuse = 0, pready, pslverr, err;
  meas_s       meas;
  logic [1:0]  alarm;
  logic [3:0]  evt;
  int          ev [4] = '{0, 0, 0, 0};
  int          n, fail_count = 0, samples_checked = 0;
  logic [7:0]  ofs [8] = '{OFS_EVT_EN, OFS_CT_HIGH, OFS_CT_LOW,
    OFS_CT_DELAY, OFS_NSV_THR, OFS_NSC_THR, OFS_VT_DELAY, OFS_STATUS};
  // Idle status: zero currents hold the low and sequence current pickups
  logic [31:0] dflt [8] = '{32'(RST_EVT_EN), 32'(RST_CT_HIGH),
    32'(RST_CT_LOW), 32'(RST_DELAY), 32'(RST_NSV_THR), 32'(RST_NSC_THR),
    32'(RST_DELAY), 32'h0000_0050};

  transformer_circuit_supervision #(.STEP_CYCLES(STEP)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .meas(meas),
    .timestamp(timestamp), .ct_alarm(alarm[0]), .vt_alarm(alarm[1]),
    .current_sup_alarm_on_event_enable_event(evt[0]), .current_sup_alarm_off_event_enable_event(evt[1]),
    .voltage_sup_alarm_on_event_enable_event(evt[2]), .voltage_sup_alarm_off_event_enable_event(evt[3]));
  meas_frontend u_fe (.pclk(pclk), .presetn(presetn), .ia(ia), .ib(ib),
    .ic(ic), .vt_fuse(vt_fuse), .meas(meas), .timestamp(timestamp));

  // 40 MHz clock
  initial
  begin
    forever #12.5 pclk = ~pclk;
  end

  // Pulse counts and stamps seen mid-cycle, away from launching edges
  always @(negedge pclk)
  begin
    foreach (ev[i])
      ev[i] += (evt[i] === 1'b1);
    // Record holds the stamp of the first alarm cycle, one count on
    if (alarm[0] !== 1'b1)
      ts_ct <= timestamp + 32'h0000_0001;
    if (alarm[1] !== 1'b1)
      ts_vt <= timestamp + 32'h0000_0001;
  end

  task automatic results();
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: saw %h wanted %h", $time, got, exp);
    end
  endtask

  // One transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the watchdog ends a wait that never sees pready
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, '0);
    check(q, exp);
  endtask

  task automatic drive(input logic [15:0] a, b, c, input logic f);
    @(posedge pclk);
    {ia, ib, ic, vt_fuse} <= {a, b, c, f};
  endtask

  // Counts mid-cycle samples until the alarm reaches the level
  task automatic wait_al(input int i, input logic lvl);
    n = 1;
    @(negedge pclk);
    while (alarm[i] !== lvl && n++ < 2000)
      @(negedge pclk);
    if (alarm[i] !== lvl)
      fail_count++;
    // Event pulse lands one edge later; let the counters see it
    repeat (2) @(negedge pclk);
  endtask

  // Watchdog: the sequence needs far fewer than 10000 cycles
  initial
  begin
    #(10000 * 25);
    fail_count++;
    results();
  end

  // Main sequence
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ofs[i])
      rd(ofs[i], dflt[i]);
    apb(1'b1, OFS_CT_DELAY, '0);
    rd(OFS_CT_DELAY, 32'(MIN_DELAY));
    apb(1'b1, OFS_CT_DELAY, 32'(RST_DELAY));
    apb(1'b1, OFS_CT_HIGH, 32'h0000_FFFF);
    rd(OFS_CT_HIGH, 32'(MAX_CT_THR));
    apb(1'b1, OFS_CT_HIGH, 32'(RST_CT_HIGH));
    apb(1'b0, 8'h38, '0);
    check(err, 1'b1);
    // Open phase among loaded phases, then reset hysteresis on high side
    drive(16'h012C, 16'h0064, 16'h000A, 1'b0);
    wait_al(0, 1'b1);
    check(n, 54);
    check(ev[0], 1);
    rd(OFS_CT_LIVE, 32'h012C_000A);
    rd(OFS_CT_REC_V, 32'h012C_000A);
    rd(OFS_CT_REC_TS, ts_ct);
    drive(16'h00C3, 16'h0064, 16'h000A, 1'b0);
    repeat (20) @(negedge pclk);
    check(alarm[0], 1'b1);
    drive(16'h00C1, 16'h0064, 16'h000A, 1'b0);
    wait_al(0, 1'b0);
    check(n, 4);
    check(ev[1], 1);
    // Condition lost mid-delay, then a full restart
    drive(16'h012C, 16'h0064, 16'h000A, 1'b0);
    repeat (30) @(negedge pclk);
    drive(16'h012C, 16'h0064, 16'h0019, 1'b0);
    repeat (60) @(negedge pclk);
    check(alarm[0], 1'b0);
    check(ev[0], 1);
    drive(16'h012C, 16'h0064, 16'h000A, 1'b0);
    wait_al(0, 1'b1);
    check(n, 54);
    drive(16'h012C, 16'h0064, 16'h0014, 1'b0);
    repeat (20) @(negedge pclk);
    check(alarm[0], 1'b1);
    drive(16'h012C, 16'h0064, 16'h0015, 1'b0);
    wait_al(0, 1'b0);
    check(n, 4);
    // Events suppressed while their enables are off
    apb(1'b1, OFS_EVT_EN, '0);
    drive(16'h012C, 16'h0064, 16'h000A, 1'b0);
    wait_al(0, 1'b1);
    drive(16'h012C, 16'h0064, 16'h0019, 1'b0);
    wait_al(0, 1'b0);
    check(ev[0], 2);
    check(ev[1], 2);
    apb(1'b1, OFS_EVT_EN, 32'h0000_000F);
    // Blown fuse with no current, then recovery and current blocking
    drive('0, '0, '0, 1'b1);
    wait_al(1, 1'b1);
    check(n, 54);
    check(ev[2], 1);
    rd(OFS_VT_REC_TS, ts_vt);
    apb(1'b0, OFS_VT_REC_V, '0);
    check(q[15:0], '0);
    check(q[31:16] > 16'h015A && q[31:16] < 16'h0258, 1'b1);
    drive('0, '0, '0, 1'b0);
    wait_al(1, 1'b0);
    check(n, 4);
    check(ev[3], 1);
    drive(16'h0190, '0, '0, 1'b1);
    repeat (80) @(negedge pclk);
    check(alarm[1], 1'b0);
    results();
  end
endmodule // tb
